/* logic/tcr_regs.svh */
`ifndef TCR_REGS_SVH
`define TCR_REGS_SVH
// register indices on the host command port
`define TCR_IDX_RESULT 2'h0
`define TCR_IDX_CONFIG 2'h1
`define TCR_IDX_LOW 2'h2
`define TCR_IDX_HIGH 2'h3
// configuration field positions
`define TCR_CFG_MODE_LO 10
`define TCR_CFG_CYC_LO 7
`define TCR_CFG_AVG_LO 5
`define TCR_CFG_FRESH 13
`define TCR_CFG_HIGH_AL 15
`define TCR_CFG_LOW_AL 14
// reset values
`define TCR_RESULT_RST 16'h8000
`define TCR_LOW_RST 16'h8000
`define TCR_HIGH_RST 16'h7FFF
`define TCR_CFG_CYC_RST 3'h4
`define TCR_CFG_AVG_RST 2'h1
// times in microseconds, clock rate in MHz
`define TCR_PWRUP_US 1500
`define TCR_CONV_US 15500
`define TCR_TMO_MIN_US 20000
`define TCR_TMO_MAX_US 40000
`define TCR_CLK_MHZ 125
`endif

/* logic/tcr_pkg.sv */
package tcr_pkg;
   // conversion mode field encodings
   typedef enum logic [1:0] {
      TCR_MODE_CONT = 2'h0,
      TCR_MODE_SHUT = 2'h1,
      TCR_MODE_CONT2 = 2'h2,
      TCR_MODE_ONESHOT = 2'h3
   } tcr_mode_t;
   typedef enum {TCR_ST_PWRUP, TCR_ST_ACTIVE, TCR_ST_STANDBY, TCR_ST_SHUT} tcr_state_t;
endpackage

/* logic/tcr_timer.sv */
`timescale 1ns/10ps
// down counter that pulses done when a loaded count runs out
module tcr_timer #(
   parameter int W = 32
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_load,
   input wire logic [W-1:0] i_count,
   output logic o_done
);
   logic [W-1:0] cnt;
   logic run;
   wire last = run && (cnt == {{(W-1){1'b0}}, 1'b1});
   // reload wins over expiry so a restart is never lost
   always_ff @(posedge i_clk) begin
      if (i_srst || i_load) begin
         cnt <= i_srst ? '0 : i_count;
         run <= !i_srst && (i_count != '0);
      end else if (run) begin
         cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
         run <= !last;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_done <= 1'b0;
      end else begin
         o_done <= last && !i_load;
      end
   end
endmodule // tcr_timer

/* logic/tcr_core.sv */
`timescale 1ns/10ps
`include "tcr_regs.svh"
// Behaviour
// - wait 1.5 ms before first conversion
// - power-up shutdown setting skips conversions
// - result reads 8000 hex until first result
// - result loads only at conversion/average end
// - result 16-bit two's complement, 7.8125 mC
// - encoding: 1 C = 0080, -LSB = FFFF
// - limits share result format, compared directly
// - alert flags and pin from limit compare
// - two-bit mode field selects operation
// - continuous cycle: active then standby
// - cycle time and averaging set periods
// - idle serial clock 20-40 ms aborts transfer
// - mode 00 converts continuously, updates each cycle
// - writing 01 aborts conversion, enters shutdown
// - writing 11 in shutdown does one conversion
// - fresh flag set at end, cleared on read
module tcr_core
   import tcr_pkg::*;
#(
   parameter int PWRUP_CYC = `TCR_PWRUP_US * `TCR_CLK_MHZ,
   parameter int CONV_CYC = `TCR_CONV_US * `TCR_CLK_MHZ,
   parameter int TMO_CYC = (`TCR_TMO_MIN_US * `TCR_CLK_MHZ + `TCR_TMO_MAX_US * `TCR_CLK_MHZ) / 2,
   parameter int UNIT_CYC = CONV_CYC
) (
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_SRST,
   // power-up strap
   input wire logic I_START_SHUTDOWN,
   // register command port from the bus front end
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [1:0] I_REG_IDX,
   input wire logic [15:0] I_REG_WDATA,
   // serial clock pin and transaction-open level
   input wire logic I_SCL,
   input wire logic I_XFER_OPEN,
   // analog front end sample
   input wire logic [15:0] I_SAMPLE,
   // outputs
   output logic [15:0] O_REG_RDATA,
   output logic O_REG_RVALID,
   output logic O_ALERT,
   output logic O_XFER_ABORT,
   output logic O_CONV_ACTIVE
);
   tcr_state_t state;
   logic [15:0] result, low_lim, high_lim;
   logic [1:0] mode, avg;
   logic [2:0] cyc;
   logic fresh, high_al, low_al, strap;
   logic [2:0] avg_cnt;
   logic signed [18:0] acc;
   logic scl_m, scl_s, scl_d, open_m, open_s, shut_m, shut_s;
   logic [31:0] idle_cnt;
   // synchronise the link pins; first stage feeds only the second
   always_ff @(posedge I_CLOCK) begin
      scl_m <= I_SCL;
      scl_s <= scl_m;
      scl_d <= scl_s;
      open_m <= I_XFER_OPEN;
      open_s <= open_m;
      shut_m <= I_START_SHUTDOWN;
      shut_s <= shut_m;
   end
   // decodes
   wire wr_cfg = I_REG_WR && (I_REG_IDX == `TCR_IDX_CONFIG);
   wire rd_cfg = I_REG_RD && (I_REG_IDX == `TCR_IDX_CONFIG);
   wire rd_res = I_REG_RD && (I_REG_IDX == `TCR_IDX_RESULT);
   wire [1:0] wr_mode = I_REG_WDATA[`TCR_CFG_MODE_LO +: 2];
   wire abort_req = wr_cfg && (wr_mode == TCR_MODE_SHUT);
   wire oneshot_req = wr_cfg && (wr_mode == TCR_MODE_ONESHOT) && (state == TCR_ST_SHUT);
   wire cont_req = wr_cfg && !wr_mode[0] && (state == TCR_ST_SHUT);
   wire [3:0] n_avg = (avg == 2'h0) ? 4'h1 : (avg == 2'h1) ? 4'h8 : (avg == 2'h2) ? 4'h8 : 4'h8;
   // wide enough for eight samples shifted by the largest cycle field
   wire [10:0] units = {7'h00, n_avg} << cyc;
   // cycle length grows with the cycle time field; must be at least the active length
   wire [31:0] cycle_len = 32'(UNIT_CYC) * 32'(units);
   wire [31:0] act_len = 32'(CONV_CYC) * 32'(n_avg);
   wire [31:0] stby_len = (cycle_len > act_len) ? cycle_len - act_len : 32'h1;
   // timer control
   logic t_load;
   logic [31:0] t_count;
   logic t_done;
   logic pwr_arm;
   // the power-up delay ends in a conversion unless the strap asks for shutdown
   wire pwr_go = (state == TCR_ST_PWRUP) && strap && t_done && !shut_s;
   tcr_timer #(.W(32)) u_timer (
      .i_clk(I_CLOCK),
      .i_srst(I_SRST),
      .i_load(t_load),
      .i_count(t_count),
      .o_done(t_done)
   );
   // one averaged sample completes when a single conversion expires
   wire conv_done = (state == TCR_ST_ACTIVE) && t_done && !abort_req;
   wire last_sample = conv_done && ({1'b0, avg_cnt} + 4'h1 >= n_avg);
   wire signed [18:0] acc_sum = acc + 19'(signed'(I_SAMPLE));
   wire signed [18:0] avg_val = (n_avg == 4'h1) ? acc_sum : (acc_sum >>> 3);
   wire [15:0] new_res = avg_val[15:0];
   wire res_hi = $signed(new_res) > $signed(high_lim);
   wire res_lo = $signed(new_res) < $signed(low_lim);
   // timer load selection
   always_comb begin
      t_load = 1'b0;
      t_count = 32'h0;
      if (I_SRST) begin
         t_load = 1'b0;
      end else if (state == TCR_ST_PWRUP && !strap) begin
         t_load = 1'b0;
      end else if (pwr_arm) begin
         t_load = 1'b1;
         t_count = 32'(PWRUP_CYC);
      end else if (oneshot_req || cont_req) begin
         t_load = 1'b1;
         t_count = 32'(CONV_CYC);
      end else if (conv_done && !last_sample) begin
         t_load = 1'b1;
         t_count = 32'(CONV_CYC);
      end else if (last_sample && mode[0] == 1'b0) begin
         t_load = 1'b1;
         t_count = stby_len;
      end else if ((state == TCR_ST_STANDBY && t_done) || pwr_go) begin
         t_load = 1'b1;
         t_count = 32'(CONV_CYC);
      end
   end
   // conversion sequencer
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         state <= TCR_ST_PWRUP;
         strap <= 1'b0;
         avg_cnt <= 3'h0;
         acc <= '0;
      end else begin
         unique case (state)
            TCR_ST_PWRUP: begin
               if (!strap) begin
                  strap <= 1'b1; // arm after release, then time the delay
               end else if (t_done) begin
                  state <= shut_s ? TCR_ST_SHUT : TCR_ST_ACTIVE;
               end
            end
            TCR_ST_ACTIVE: begin
               if (abort_req) begin
                  state <= TCR_ST_SHUT;
                  avg_cnt <= 3'h0;
                  acc <= '0;
               end else if (last_sample) begin
                  avg_cnt <= 3'h0;
                  acc <= '0;
                  state <= mode[0] ? TCR_ST_SHUT : TCR_ST_STANDBY;
               end else if (conv_done) begin
                  avg_cnt <= avg_cnt + 3'h1;
                  acc <= acc_sum;
               end
            end
            TCR_ST_STANDBY: begin
               if (abort_req) begin
                  state <= TCR_ST_SHUT;
               end else if (t_done) begin
                  state <= TCR_ST_ACTIVE;
               end
            end
            TCR_ST_SHUT: begin
               if (oneshot_req || cont_req) begin
                  state <= TCR_ST_ACTIVE;
               end
            end
         endcase
      end
   end
   // power-up delay load happens once the strap stage is armed
   always_ff @(posedge I_CLOCK) begin
      pwr_arm <= !I_SRST && (state == TCR_ST_PWRUP) && !strap;
   end
   // registers and flags; a set event wins over a read clear
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         result <= `TCR_RESULT_RST;
         low_lim <= `TCR_LOW_RST;
         high_lim <= `TCR_HIGH_RST;
         mode <= TCR_MODE_CONT;
         cyc <= `TCR_CFG_CYC_RST;
         avg <= `TCR_CFG_AVG_RST;
         fresh <= 1'b0;
         high_al <= 1'b0;
         low_al <= 1'b0;
      end else begin
         if (last_sample) begin
            result <= new_res;
         end
         if (wr_cfg) begin
            mode <= wr_mode;
            cyc <= I_REG_WDATA[`TCR_CFG_CYC_LO +: 3];
            avg <= I_REG_WDATA[`TCR_CFG_AVG_LO +: 2];
         end
         if (I_REG_WR && I_REG_IDX == `TCR_IDX_LOW) begin
            low_lim <= I_REG_WDATA;
         end
         if (I_REG_WR && I_REG_IDX == `TCR_IDX_HIGH) begin
            high_lim <= I_REG_WDATA;
         end
         fresh <= last_sample || (fresh && !(rd_cfg || rd_res));
         high_al <= (last_sample && res_hi) || (high_al && !rd_cfg);
         low_al <= (last_sample && res_lo) || (low_al && !rd_cfg);
      end
   end
   // read data is captured whole in one edge so both bytes match
   wire [15:0] cfg_word = {high_al, low_al, fresh, 1'b0, mode, cyc, avg, 5'h00};
   wire [15:0] rd_mux = (I_REG_IDX == `TCR_IDX_RESULT) ? result :
                        (I_REG_IDX == `TCR_IDX_CONFIG) ? cfg_word :
                        (I_REG_IDX == `TCR_IDX_LOW) ? low_lim : high_lim;
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         O_REG_RDATA <= 16'h0000;
         O_REG_RVALID <= 1'b0;
      end else begin
         O_REG_RVALID <= I_REG_RD;
         if (I_REG_RD) begin
            O_REG_RDATA <= rd_mux;
         end
      end
   end
   // bus timeout: serial clock idle while a transfer is open
   wire scl_edge = scl_s ^ scl_d;
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST || !open_s || scl_edge) begin
         idle_cnt <= 32'h0;
         O_XFER_ABORT <= 1'b0;
      end else if (idle_cnt >= 32'(TMO_CYC) - 32'h1) begin
         O_XFER_ABORT <= 1'b1;
      end else begin
         idle_cnt <= idle_cnt + 32'h1;
         O_XFER_ABORT <= 1'b0;
      end
   end
   // status outputs
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         O_ALERT <= 1'b0;
         O_CONV_ACTIVE <= 1'b0;
      end else begin
         O_ALERT <= high_al || low_al;
         O_CONV_ACTIVE <= (state == TCR_ST_ACTIVE);
      end
   end
endmodule // tcr_core

/* dv/tcr_core_assertions.sv */
`timescale 1ns/10ps
// port-level relations of the conversion core
module tcr_core_assertions #(
   parameter int PWRUP_CYC = 20,
   parameter int TMO_CYC = 50
) (
   input wire logic I_CLOCK,
   input wire logic I_SRST,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [1:0] I_REG_IDX,
   input wire logic [15:0] I_REG_WDATA,
   input wire logic I_SCL,
   input wire logic I_XFER_OPEN,
   input wire logic [15:0] O_REG_RDATA,
   input wire logic O_REG_RVALID,
   input wire logic O_XFER_ABORT,
   input wire logic O_CONV_ACTIVE
);
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_SRST);
   int up_cnt;
   int idle_cnt;
   logic conv_seen;
   // raw-pin counters lead the synchronised view inside, so the bounds stay safe
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         up_cnt <= 0;
         idle_cnt <= 0;
         conv_seen <= 1'b0;
      end else begin
         up_cnt <= (up_cnt < PWRUP_CYC) ? up_cnt + 1 : up_cnt;
         idle_cnt <= (!I_XFER_OPEN || I_SCL != $past(I_SCL)) ? 0 : idle_cnt + 1;
         conv_seen <= conv_seen || O_CONV_ACTIVE;
      end
   end
   // a limit write directly followed by a read of the same limit
   sequence lim_wr_s;
      I_REG_WR && I_REG_IDX[1];
   endsequence
   sequence lim_rd_s;
      I_REG_RD && !I_REG_WR && I_REG_IDX == $past(I_REG_IDX);
   endsequence
   AST_LIMIT_RD: assert property (
      lim_wr_s ##1 lim_rd_s |=> O_REG_RDATA == $past(I_REG_WDATA, 2))
      else $error("limit readback differs");
   AST_RD_ANSWER: assert property (I_REG_RD |=> O_REG_RVALID)
      else $error("read got no answer");
   AST_RDATA_HOLD: assert property (!O_REG_RVALID |-> $stable(O_REG_RDATA))
      else $error("read data moved without a read");
   AST_RESULT_INIT: assert property (
      I_REG_RD && I_REG_IDX == 2'h0 && !conv_seen |=> O_REG_RDATA == 16'h8000)
      else $error("result not at reset code");
   AST_PWRUP_WAIT: assert property (up_cnt < PWRUP_CYC |-> !O_CONV_ACTIVE)
      else $error("conversion before power-up delay");
   AST_ABORT_LATE: assert property ($rose(O_XFER_ABORT) |-> idle_cnt >= TMO_CYC)
      else $error("abort before timeout");
   AST_ABORT_CLR: assert property (!I_XFER_OPEN [*4] |-> !O_XFER_ABORT)
      else $error("abort stays after transfer closed");
   AST_SHUT_NOW: assert property (
      I_REG_WR && I_REG_IDX == 2'h1 && I_REG_WDATA[11:10] == 2'h1 |-> ##3 !O_CONV_ACTIVE [*4])
      else $error("conversion not stopped by shutdown");
endmodule // tcr_core_assertions

bind tcr_core tcr_core_assertions #(.PWRUP_CYC(PWRUP_CYC), .TMO_CYC(TMO_CYC))
   i_tcr_core_assertions (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_REG_WR(I_REG_WR),
   .I_REG_RD(I_REG_RD), .I_REG_IDX(I_REG_IDX), .I_REG_WDATA(I_REG_WDATA), .I_SCL(I_SCL),
   .I_XFER_OPEN(I_XFER_OPEN), .O_REG_RDATA(O_REG_RDATA), .O_REG_RVALID(O_REG_RVALID),
   .O_XFER_ABORT(O_XFER_ABORT), .O_CONV_ACTIVE(O_CONV_ACTIVE));

/* dv/tcr_host.sv */
`timescale 1ns/10ps
// host stand-in: register commands, serial clock only inside frames
module tcr_host (
   input wire logic i_clk,
   output logic o_wr,
   output logic o_rd,
   output logic [1:0] o_idx,
   output logic [15:0] o_wdata,
   output logic o_scl,
   output logic o_open
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_idx = 2'h0;
      o_wdata = 16'h0;
      o_scl = 1'b1;
      o_open = 1'b0;
   end
   // one command per edge; entered just after an edge so commands chain
   task automatic cmd(input logic wr, input logic [1:0] idx, input logic [15:0] d);
      o_wr = wr;
      o_rd = !wr;
      o_idx = idx;
      o_wdata = d;
      @(posedge i_clk);
      #1;
   endtask
   // released data shows the inverse so a stale value never passes
   task automatic idle();
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = ~o_wdata;
   endtask
   // a few clocks, then the line is left still with the frame open
   task automatic frame(input int n);
      o_open = 1'b1;
      repeat (n) begin
         #40 o_scl = 1'b0;
         #40 o_scl = 1'b1;
      end
   endtask
   task automatic close();
      o_open = 1'b0;
   endtask
endmodule // tcr_host

/* dv/tb.sv */
`timescale 1ns/10ps
`include "tcr_regs.svh"
// self-checking bench for the conversion core
module tb;
   localparam int PWRUP = 20;
   localparam int TMO = 50;
   logic clk, srst, strap, wr, rd, scl, open, rvalid, alert, abort, active;
   logic [1:0] idx;
   logic [15:0] wdata, rdata, sample, s;
   logic [31:0] note;
   logic [31:0] exp_q[$];
   int num_errors = 0;
   int checks = 0;
   tcr_core #(.PWRUP_CYC(PWRUP), .CONV_CYC(10), .TMO_CYC(TMO), .UNIT_CYC(10)) i_tcr_core (
      .I_CLOCK(clk), .I_SRST(srst), .I_START_SHUTDOWN(strap), .I_REG_WR(wr), .I_REG_RD(rd),
      .I_REG_IDX(idx), .I_REG_WDATA(wdata), .I_SCL(scl), .I_XFER_OPEN(open), .I_SAMPLE(sample),
      .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .O_ALERT(alert), .O_XFER_ABORT(abort),
      .O_CONV_ACTIVE(active));
   tcr_host i_tcr_host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_idx(idx), .o_wdata(wdata),
      .o_scl(scl), .o_open(open));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // note the masked expectation, then issue the read
   task automatic rd_exp(input logic [1:0] i, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
      exp_q.push_back({m, e & m});
      i_tcr_host.cmd(1'b0, i, 16'h0);
   endtask
   // bounded wait for the conversion flag to reach a level
   task automatic wait_level(input logic lvl, input int lim);
      int n = 0;
      while (active !== lvl && n < lim) begin
         @(posedge clk);
         n++;
      end
      #1;
      check({15'h0, active}, {15'h0, lvl});
   endtask
   // oldest note is matched against each read answer; falling edge avoids the launch race
   always @(negedge clk) begin
      if (rvalid === 1'b1) begin
         note = (exp_q.size() > 0) ? exp_q.pop_front() : {16'hFFFF, ~rdata};
         check(rdata & note[31:16], note[15:0]);
      end
   end
   initial begin
      #100000;
      num_errors++;
      wrap_up();
   end
   initial begin
      srst = 1'b1;
      strap = 1'b1;
      sample = 16'h0;
      void'($urandom(90));
      cyc(2);
      srst = 1'b0;
      rd_exp(`TCR_IDX_RESULT, 16'h8000);
      rd_exp(`TCR_IDX_LOW, 16'h8000);
      rd_exp(`TCR_IDX_HIGH, 16'h7FFF);
      i_tcr_host.idle();
      cyc(PWRUP + 40);
      check({15'h0, active}, 16'h0);
      $display("test strap done");
      // one-shot against high, low and no limit crossing
      for (int k = 0; k < 3; k++) begin
         s = 16'($urandom_range(30000, 0)) - 16'd15000;
         sample = s;
         i_tcr_host.cmd(1'b1, `TCR_IDX_LOW, (k == 1) ? s + 16'h1 : 16'h8000);
         i_tcr_host.cmd(1'b1, `TCR_IDX_HIGH, (k == 0) ? s - 16'h1 : 16'h7FFF);
         rd_exp(`TCR_IDX_HIGH, (k == 0) ? s - 16'h1 : 16'h7FFF);
         i_tcr_host.cmd(1'b1, `TCR_IDX_CONFIG, 16'h0C00);
         i_tcr_host.idle();
         wait_level(1'b1, 20);
         wait_level(1'b0, 40);
         cyc(4);
         check({15'h0, alert}, {15'h0, k < 2});
         rd_exp(`TCR_IDX_CONFIG, {k == 0, k == 1, 14'h2000}, 16'hE000);
         rd_exp(`TCR_IDX_CONFIG, 16'h0, 16'hE000);
         rd_exp(`TCR_IDX_RESULT, s);
         i_tcr_host.idle();
         cyc(2);
      end
      $display("test one-shot done");
      strap = 1'b0;
      srst = 1'b1;
      cyc(2);
      srst = 1'b0;
      wait_level(1'b1, PWRUP + 20);
      wait_level(1'b0, 100);
      cyc(3);
      rd_exp(`TCR_IDX_RESULT, s);
      i_tcr_host.idle();
      cyc(20);
      check({15'h0, active}, 16'h0);
      wait_level(1'b1, 1300);
      i_tcr_host.cmd(1'b1, `TCR_IDX_CONFIG, 16'h0400);
      i_tcr_host.idle();
      sample = ~s;
      cyc(300);
      rd_exp(`TCR_IDX_RESULT, s);
      i_tcr_host.idle();
      $display("test continuous done");
      i_tcr_host.frame(4);
      cyc(TMO - 10);
      check({15'h0, abort}, 16'h0);
      cyc(20);
      check({15'h0, abort}, 16'h1);
      i_tcr_host.close();
      cyc(6);
      check({15'h0, abort}, 16'h0);
      $display("test timeout done");
      check(16'(exp_q.size()), 16'h0);
      wrap_up();
   end
endmodule // tb
